//--- core/sss_sample_scheduler.sv
// Single-shunt sample scheduler: center-aligned three-phase PWM with
// minimum-pulse or phase-shift shaping, ADC trigger placement and
// phase current reconstruction from the two DC link samples.
// Assumes all inputs except rst_n come from logic on the timer clock.
`timescale 1ns/100ps
`default_nettype none
`include "sss_cfg.svh"

// How it works
// - Aim DC link samples at active vectors; a large delay moves them out
// - Two active vectors; third current from zero sum
// - Two-high vector gives negated low-phase current
// - Basic sense point: start plus half plus delay
// - Signed sample delay in timer ticks
// - Late sense points pulled to cycle end
// - Minimum-pulse mode stretches short vectors
// - Minimum-pulse mode senses at vector midpoint plus delay
// - Shift window counted in timer ticks
// - Long enough vectors keep centered pattern
// - Short vectors shift phases at falling edge
// - One-high vector short: high later, mid earlier
// - Two-high vector short: low phase earlier
// - Over two windows: sense at midpoint plus delay
// - One to two windows: sense window plus delay
// - Short vector: sense delay after extended window
// - Shifts keep each phase width unchanged
module sss_sample_scheduler
   import sss_pkg::*;
#(
   parameter int CW = `SSS_CNT_W,
   parameter int DLW = `SSS_DLY_W,
   parameter int DW = `SSS_ADC_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [CW-1:0] half_period,
   input wire logic [CW-1:0] duty_u,
   input wire logic [CW-1:0] duty_v,
   input wire logic [CW-1:0] duty_w,
   input wire logic mode_shift,
   input wire logic [CW-1:0] min_pulse_count,
   input wire logic [CW-1:0] min_shift_window,
   input wire logic signed [DLW-1:0] sample_delay_setting,
   input wire logic adc_valid,
   input wire logic signed [DW-1:0] adc_data,
   output logic pwm_u,
   output logic pwm_v,
   output logic pwm_w,
   output logic adc_trigger,
   output logic trigger_second,
   output logic cycle_start,
   output logic signed [DW:0] cur_u,
   output logic signed [DW:0] cur_v,
   output logic signed [DW:0] cur_w,
   output logic cur_valid
);

   localparam int SW = CW + 4;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_s1_q;
   logic rst_s2_q;
   wire logic rst_sync_n = rst_s2_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ****************************************************************
   // Cycle timer and per-cycle settings
   // ****************************************************************
   logic [CW:0] t_q;
   logic [CW-1:0] p_q;
   logic [CW-1:0] d_q [3];
   logic [CW-1:0] tmin_q;
   logic [CW-1:0] win_q;
   logic signed [DLW-1:0] dly_q;
   sss_mode_type mode_q;

   wire logic [CW+1:0] t_next = (CW+2)'(t_q) + (CW+2)'(1);
   wire logic cyc_end = t_next >= (CW+2)'({p_q, 1'b0});

   // Settings change only at the boundary, so one cycle never mixes two patterns
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         t_q <= '0;
         p_q <= '0;
         d_q <= '{default: '0};
         tmin_q <= '0;
         win_q <= '0;
         dly_q <= '0;
         mode_q <= sss_mode_type'(`SSS_MODE_RST);
      end else if (cyc_end) begin
         t_q <= '0;
         p_q <= half_period;
         d_q <= '{duty_u, duty_v, duty_w};
         tmin_q <= min_pulse_count;
         win_q <= min_shift_window;
         dly_q <= sample_delay_setting;
         mode_q <= sss_mode_type'(mode_shift);
      end else begin
         t_q <= t_next[CW:0];
      end
   end

   // ****************************************************************
   // Phase ordering
   // ****************************************************************
   wire logic uv = d_q[0] >= d_q[1];
   wire logic vw = d_q[1] >= d_q[2];
   wire logic uw = d_q[0] >= d_q[2];
   wire sss_phase_type hi_i = (uv && uw) ? 2'h0 : (!uv && vw) ? 2'h1 : 2'h2;
   wire sss_phase_type lo_i = (!uv && !uw) ? 2'h0 : (uv && !vw) ? 2'h1 : 2'h2;
   wire sss_phase_type mid_i = 2'h3 - hi_i - lo_i;
   wire logic is_shift = mode_q == SSS_SHIFT;

   wire logic signed [SW-1:0] per = $signed(SW'(p_q));
   wire logic signed [SW-1:0] full = $signed(SW'({p_q, 1'b0}));
   wire logic signed [SW-1:0] dlo = $signed(SW'(d_q[lo_i]));
   wire logic signed [SW-1:0] dmid = $signed(SW'(d_q[mid_i]));
   wire logic signed [SW-1:0] dhi = $signed(SW'(d_q[hi_i]));
   wire logic signed [SW-1:0] tmin = $signed(SW'(tmin_q));
   wire logic signed [SW-1:0] win = $signed(SW'(win_q));
   wire logic signed [SW-1:0] dly = SW'(dly_q);
   wire logic signed [SW-1:0] tnow = $signed(SW'(t_q));

   // ****************************************************************
   // Minimum-pulse stretching, symmetric about the center
   // ****************************************************************
   // Stretching distorts the average voltage; that is the price of this mode
   wire logic signed [SW-1:0] mid_need = dlo + tmin;
   wire logic signed [SW-1:0] dmid_p = (dmid < mid_need) ? mid_need : dmid;
   wire logic signed [SW-1:0] hi_need = dmid_p + tmin;
   wire logic signed [SW-1:0] dhi_p = (dhi < hi_need) ? hi_need : dhi;

   // ****************************************************************
   // Phase shift at the falling edge
   // ****************************************************************
   wire logic signed [SW-1:0] ta = dhi - dmid;
   wire logic signed [SW-1:0] tb = dmid - dlo;
   // Zero shift when a vector already meets the window
   wire logic signed [SW-1:0] sa = (ta < win) ? win - ta : '0;
   wire logic signed [SW-1:0] sm = sa >>> 1;
   wire logic signed [SW-1:0] sh = sa - sm;
   wire logic signed [SW-1:0] tbe = tb - sm;
   wire logic signed [SW-1:0] sl = (tbe < win) ? win - tbe : '0;

   wire logic signed [SW-1:0] de_lo = dlo;
   wire logic signed [SW-1:0] de_mid = is_shift ? dmid : dmid_p;
   wire logic signed [SW-1:0] de_hi = is_shift ? dhi : dhi_p;
   wire logic signed [SW-1:0] s_lo = is_shift ? -sl : '0;
   wire logic signed [SW-1:0] s_mid = is_shift ? -sm : '0;
   wire logic signed [SW-1:0] s_hi = is_shift ? sh : '0;

   logic [2:0] pwm_d;
   logic [2:0] pwm_q;

   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_phase
         wire logic is_hi = hi_i == sss_phase_type'(gp);
         wire logic is_lo = lo_i == sss_phase_type'(gp);
         wire logic signed [SW-1:0] de = is_hi ? de_hi : is_lo ? de_lo : de_mid;
         wire logic signed [SW-1:0] sx = is_hi ? s_hi : is_lo ? s_lo : s_mid;
         // Both edges move together, so the on-time and the average stay put
         wire logic signed [SW-1:0] rise = per - de + sx;
         wire logic signed [SW-1:0] fall = per + de + sx;
         assign pwm_d[gp] = (tnow >= rise) && (tnow < fall);
      end
   endgenerate

   // ****************************************************************
   // Sense points
   // ****************************************************************
   wire logic signed [SW-1:0] fl = per + de_lo + s_lo;
   wire logic signed [SW-1:0] fm = per + de_mid + s_mid;
   wire logic signed [SW-1:0] fh = per + de_hi + s_hi;
   wire logic signed [SW-1:0] len1 = fm - fl;
   wire logic signed [SW-1:0] len2 = fh - fm;
   wire logic signed [SW-1:0] win2 = win <<< 1;
   wire logic use_win1 = is_shift && (tb <= win2);
   wire logic use_win2 = is_shift && (ta <= win2);
   wire logic signed [SW-1:0] mid1 = fl + (len1 >>> 1) + dly;
   wire logic signed [SW-1:0] mid2 = fm + (len2 >>> 1) + dly;
   wire logic signed [SW-1:0] sp1 = use_win1 ? fl + win + dly : mid1;
   wire logic signed [SW-1:0] sp2 = use_win2 ? fm + win + dly : mid2;

   // Second point sits after the first so that the two never collide
   wire logic signed [SW-1:0] lim1 = full - SW'(2);
   wire logic signed [SW-1:0] lim2 = full - SW'(1);
   wire logic signed [SW-1:0] sp1_hi = (sp1 > lim1) ? lim1 : sp1;
   wire logic signed [SW-1:0] first_sense_point = (sp1_hi < 0) ? '0 : sp1_hi;
   wire logic signed [SW-1:0] sp2_hi = (sp2 > lim2) ? lim2 : sp2;
   wire logic signed [SW-1:0] sp2_lo = first_sense_point + SW'(1);
   wire logic signed [SW-1:0] second_sense_point = (sp2_hi < sp2_lo) ? sp2_lo : sp2_hi;

   // Triggers target the two active vectors of the falling half; a large delay can move them outside, up to the cycle-end clamp
   wire logic trig1 = tnow == first_sense_point;
   wire logic trig2 = tnow == second_sense_point;

   // ****************************************************************
   // Sample capture and current reconstruction
   // ****************************************************************
   sss_cap_type cap_q;
   sss_cap_type cap_d;
   logic signed [DW-1:0] s1_q;
   logic signed [DW-1:0] s2_q;
   sss_phase_type hi_snap_q;
   sss_phase_type lo_snap_q;
   logic signed [DW:0] cur_d [3];
   logic signed [DW:0] cur_q [3];
   logic cur_valid_q;

   // A new first trigger restarts capture, dropping a pair that never completed
   always_comb begin
      cap_d = cap_q;
      unique case (cap_q)
         SSS_CAP_FIRST: begin
            if (adc_valid) begin
               cap_d = SSS_CAP_SECOND;
            end
         end
         SSS_CAP_SECOND: begin
            if (adc_valid) begin
               cap_d = SSS_CAP_DONE;
            end
         end
         SSS_CAP_DONE: begin
            cap_d = SSS_CAP_FIRST;
         end
         default: begin
            cap_d = SSS_CAP_FIRST;
         end
      endcase
      if (trig1) begin
         cap_d = SSS_CAP_FIRST;
      end
   end

   wire logic signed [DW:0] i_first = -(DW+1)'(s1_q);
   wire logic signed [DW:0] i_second = (DW+1)'(s2_q);
   wire logic signed [DW:0] i_third = (DW+1)'(s1_q) - (DW+1)'(s2_q);

   genvar gc;
   generate
      for (gc = 0; gc < 3; gc++) begin : g_cur
         assign cur_d[gc] = (lo_snap_q == sss_phase_type'(gc)) ? i_first :
            (hi_snap_q == sss_phase_type'(gc)) ? i_second : i_third;
      end
   endgenerate

   wire logic cap_first_take = (cap_q == SSS_CAP_FIRST) && adc_valid && !trig1;
   wire logic cap_second_take = (cap_q == SSS_CAP_SECOND) && adc_valid && !trig1;
   wire logic cur_load = cap_q == SSS_CAP_DONE;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cap_q <= SSS_CAP_FIRST;
         s1_q <= '0;
         s2_q <= '0;
         hi_snap_q <= 2'h0;
         lo_snap_q <= 2'h2;
      end else begin
         cap_q <= cap_d;
         if (cap_first_take) begin
            s1_q <= adc_data;
         end
         if (cap_second_take) begin
            s2_q <= adc_data;
         end
         if (trig1) begin
            hi_snap_q <= hi_i;
            lo_snap_q <= lo_i;
         end
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   logic trig_q;
   logic second_q;
   logic start_q;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwm_q <= 3'h0;
         trig_q <= 1'b0;
         second_q <= 1'b0;
         start_q <= 1'b0;
         cur_q <= '{default: '0};
         cur_valid_q <= 1'b0;
      end else begin
         pwm_q <= pwm_d;
         trig_q <= trig1 || trig2;
         second_q <= trig2;
         start_q <= cyc_end;
         cur_valid_q <= cur_load;
         if (cur_load) begin
            cur_q <= cur_d;
         end
      end
   end

   assign pwm_u = pwm_q[0];
   assign pwm_v = pwm_q[1];
   assign pwm_w = pwm_q[2];
   assign adc_trigger = trig_q;
   assign trigger_second = second_q;
   assign cycle_start = start_q;
   assign cur_u = cur_q[0];
   assign cur_v = cur_q[1];
   assign cur_w = cur_q[2];
   assign cur_valid = cur_valid_q;

endmodule
`default_nettype wire

//--- core/sss_cfg.svh
// Constants of the single-shunt sample scheduler: widths, tick unit, reset values.
// Assumes the timer clock period is the 10.417 ns tick of every setting.
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SSS_TICK_PS 10417
`define SSS_CLK_PS 10417
`define SSS_CYC_PER_TICK ((`SSS_TICK_PS + `SSS_CLK_PS - 1) / `SSS_CLK_PS)

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define SSS_CNT_W 16
`define SSS_DLY_W 8
`define SSS_ADC_W 12
`define SSS_MODE_RST 1'b0

`endif

//--- core/sss_pkg.sv
// Types shared by the single-shunt sample scheduler.
// Assumes sss_cfg.svh is on the include path.
`default_nettype none
package sss_pkg;

   // ****************************************************************
   // Modulation scheme and capture state
   // ****************************************************************
   typedef enum logic {
      SSS_MINPULSE = 1'b0,
      SSS_SHIFT = 1'b1
   } sss_mode_type;

   typedef enum logic [2:0] {
      SSS_CAP_FIRST = 3'b001,
      SSS_CAP_SECOND = 3'b010,
      SSS_CAP_DONE = 3'b100
   } sss_cap_type;

   typedef logic [1:0] sss_phase_type;

endpackage
`default_nettype wire

//--- test/sss_adc_model.sv
// Behavioural shunt ADC: answers each trigger after a set latency.
// Assumes triggers are one-cycle pulses on the timer clock.
`timescale 1ns/100ps
`default_nettype none
module sss_adc_model #(
   parameter int DW = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic adc_trigger,
   input wire logic trigger_second,
   input wire logic [3:0] lat,
   input wire logic signed [DW-1:0] s1,
   input wire logic signed [DW-1:0] s2,
   output logic adc_valid,
   output logic signed [DW-1:0] adc_data
);
   // ******
   // Conversion pipeline
   // ******
   logic [15:0] vq;
   logic [15:0] sq;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vq <= 16'h0000;
         sq <= 16'h0000;
         adc_valid <= 1'b0;
         adc_data <= '0;
      end else begin
         vq <= {vq[14:0], adc_trigger};
         sq <= {sq[14:0], trigger_second};
         adc_valid <= vq[lat];
         // Data toggles when idle so a stale value is never mistaken for a result
         adc_data <= vq[lat] ? (sq[lat] ? s2 : s1) : ~adc_data;
      end
   end
endmodule
`default_nettype wire

//--- test/sss_sched_props.sv
// Port checks of the sample scheduler, bound into each instance.
// Assumes half_period is held steady while running.
`timescale 1ns/100ps
`default_nettype none
module sss_sched_props #(
   parameter int CW = 16,
   parameter int DW = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [CW-1:0] half_period,
   input wire logic [CW-1:0] duty_u,
   input wire logic mode_shift,
   input wire logic adc_valid,
   input wire logic pwm_u,
   input wire logic adc_trigger,
   input wire logic trigger_second,
   input wire logic cycle_start,
   input wire logic signed [DW:0] cur_u,
   input wire logic signed [DW:0] cur_v,
   input wire logic signed [DW:0] cur_w,
   input wire logic cur_valid
);
   // ******
   // Counters
   // ******
   // Start-up cycles run before the first latch, so they are not judged
   logic [15:0] live_q;
   logic [15:0] quiet_q;
   logic [CW-1:0] per_q;
   logic [CW-1:0] hi_q;
   logic [1:0] trg_q;
   logic live;
   assign live = live_q > 16'h012C;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live_q <= 16'h0000;
         quiet_q <= 16'h0000;
         per_q <= '0;
         hi_q <= '0;
         trg_q <= 2'b00;
      end else begin
         live_q <= live ? live_q : live_q + 16'h0001;
         quiet_q <= ($changed(duty_u) || $changed(mode_shift)) ? 16'h0000 :
            (quiet_q[15] ? quiet_q : quiet_q + 16'h0001);
         per_q <= cycle_start ? CW'(1) : per_q + CW'(1);
         hi_q <= pwm_u ? hi_q + CW'(1) : '0;
         trg_q <= cycle_start ? 2'b00 : trg_q + {1'b0, adc_trigger};
      end
   end
   // ******
   // Assertions
   // ******
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence u_fall;
      $fell(pwm_u) && quiet_q > 16'h00C8 && mode_shift;
   endsequence
   trig_pair_a: assert property (trigger_second |-> adc_trigger)
      else $error("second trigger alone");
   trig_count_a: assert property (cycle_start && live |-> trg_q + adc_trigger == 2)
      else $error("not two sense points in a cycle");
   period_len_a: assert property (cycle_start && live |->
      {1'b0, per_q} == {half_period, 1'b0})
      else $error("cycle length wrong");
   start_gap_a: assert property (cycle_start && live |=> !cycle_start [*8])
      else $error("cycle start too soon");
   cur_sum_a: assert property (cur_valid |-> (cur_u + cur_v + cur_w) == '0)
      else $error("currents do not sum to zero");
   cur_hold_a: assert property (!cur_valid |->
      $stable(cur_u) && $stable(cur_v) && $stable(cur_w))
      else $error("currents changed without valid");
   cur_answer_a: assert property (cur_valid |-> $past(adc_valid, 2))
      else $error("currents not two cycles after sample");
   valid_pulse_a: assert property (cur_valid |=> !cur_valid)
      else $error("valid longer than one cycle");
   width_keep_a: assert property (u_fall |-> {1'b0, hi_q} == {duty_u, 1'b0})
      else $error("shifted phase width changed");
endmodule
bind sss_sample_scheduler sss_sched_props #(.CW(CW), .DW(DW)) u_props (.clk, .rst_n,
   .half_period, .duty_u, .mode_shift, .adc_valid, .pwm_u, .adc_trigger, .trigger_second,
   .cycle_start, .cur_u, .cur_v, .cur_w, .cur_valid);
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the sample scheduler: case table, then a mid-run reset.
// Assumes the ADC model beside it and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
   $display("[FAIL] %s exp %0d got %0d", nm, ex, got); end end
module tb;
   typedef struct {
      logic m;
      logic [15:0] du, dv, dw, mn;
      logic signed [7:0] dl;
      logic [3:0] lt;
      int p1, p2, lo, hi, wu, wv, ww;
   } sss_row_type;
   // ******
   // Cases: mode, duties, window, delay, latency, points, low, high, widths u v w
   // ******
   // Points are ticks after the cycle start pulse, one more than the internal tick
   sss_row_type rows [7] = '{
      '{0, 30, 20, 10, 2, 0, 1, 56, 66, 2, 0, 60, 40, 20},
      '{0, 12, 11, 10, 4, 0, 3, 53, 57, 2, 0, 36, 28, 20},
      '{1, 10, 30, 20, 4, 3, 2, 59, 69, 0, 1, 20, 60, 40},
      '{1, 18, 24, 30, 4, -2, 5, 61, 67, 0, 2, 36, 48, 60},
      '{1, 22, 20, 10, 6, 0, 1, 57, 65, 2, 0, 44, 40, 20},
      '{1, 30, 12, 10, 6, 0, 4, 53, 62, 2, 0, 60, 24, 20},
      '{0, 30, 20, 10, 2, 40, 12, 79, 80, 2, 0, 60, 40, 20}
   };
   logic clk = 1'b0;
   logic rst_n, mode_shift, adc_valid, pwm_u, pwm_v, pwm_w, adc_trigger, trigger_second;
   logic cycle_start, cur_valid;
   logic [15:0] half_period, duty_u, duty_v, duty_w, min_pulse_count, min_shift_window;
   logic signed [7:0] sample_delay_setting;
   logic signed [11:0] adc_data, s1, s2;
   logic signed [12:0] cur_u, cur_v, cur_w;
   logic [3:0] lat;
   int mismatches, check_count, cycles, cnt, pos1, pos2;
   int e [3];
   int hc [3];
   int wd [3];
   logic [2:0] pw;
   assign pw = {pwm_w, pwm_v, pwm_u};
   initial forever #5 clk = ~clk;
   sss_sample_scheduler uut (.clk, .rst_n, .half_period, .duty_u, .duty_v, .duty_w,
      .mode_shift, .min_pulse_count, .min_shift_window, .sample_delay_setting, .adc_valid,
      .adc_data, .pwm_u, .pwm_v, .pwm_w, .adc_trigger, .trigger_second, .cycle_start, .cur_u,
      .cur_v, .cur_w, .cur_valid);
   sss_adc_model adc (.clk, .rst_n, .adc_trigger, .trigger_second, .lat, .s1, .s2,
      .adc_valid, .adc_data);
   // ******
   // Monitor and timeout
   // ******
   always @(posedge clk) begin
      if (adc_trigger && !trigger_second) pos1 = cnt;
      if (trigger_second) pos2 = cnt;
      cnt = cycle_start ? 1 : cnt + 1;
      // High time of each phase, latched at its falling edge
      foreach (hc[k]) begin
         if (pw[k]) hc[k] = hc[k] + 1;
         else if (hc[k] != 0) begin
            wd[k] = hc[k];
            hc[k] = 0;
         end
      end
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic wait_starts(input int n);
      repeat (n) begin
         do @(negedge clk); while (cycle_start !== 1'b1);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      half_period = 16'h0028;
      {duty_u, duty_v, duty_w, min_pulse_count, min_shift_window} = '0;
      mode_shift = 1'b0;
      sample_delay_setting = 8'h00;
      {lat, s1, s2} = '0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         mode_shift = rows[i].m;
         duty_u = rows[i].du;
         duty_v = rows[i].dv;
         duty_w = rows[i].dw;
         min_pulse_count = rows[i].mn;
         min_shift_window = rows[i].mn;
         sample_delay_setting = rows[i].dl;
         lat = rows[i].lt;
         s1 = 12'(100 + 16 * i);
         s2 = 12'(37 * i - 200);
         e[rows[i].lo] = -(100 + 16 * i);
         e[rows[i].hi] = 37 * i - 200;
         e[3 - rows[i].lo - rows[i].hi] = 300 - 21 * i;
         wait_starts(4);
         `CHK("first point", rows[i].p1, pos1)
         `CHK("second point", rows[i].p2, pos2)
         `CHK("width u", rows[i].wu, wd[0])
         `CHK("width v", rows[i].wv, wd[1])
         `CHK("width w", rows[i].ww, wd[2])
         `CHK("current u", e[0], cur_u)
         `CHK("current v", e[1], cur_v)
         `CHK("current w", e[2], cur_w)
         $display("case %0d done", i);
      end
      // A reset in mid-run must drop the pair and relatch the settings
      rst_n = 1'b0;
      @(negedge clk);
      `CHK("valid in reset", 0, cur_valid)
      `CHK("current u in reset", 0, cur_u)
      rst_n = 1'b1;
      wait_starts(4);
      `CHK("first point again", 79, pos1)
      `CHK("current w again", e[2], cur_w)
      $display("reset case done");
      end_sim();
   end
endmodule
`default_nettype wire
